// ==== rtl/emd_end_of_message.v ====
// sync pattern b matcher, end-of-message criteria, serial register port and noise readouts
//
// Summary of operation
// - low byte of pattern b per set
// - high byte of pattern b per set
// - sync loss ends message when enabled
// - code violation ends message when enabled
// - length limit reached ends message when enabled
// - criteria combine, first occurring one ends
// - bit counting starts after last sync chip
// - limit zero ends on first bit
// - frequency shift noise readable, eight bits
// - amplitude shift noise readable, six bits
// - pattern b sequential, parallel or after gap
// - payload peak captured at end, reset clears
`timescale 1ns/10ps
`include "emd_regs.vh"
module emd_end_of_message (
  input  wire       i_clk,
  input  wire       i_reset_n,
  input  wire       i_spi_clk,
  input  wire       i_spi_cs_n,
  input  wire       i_spi_mosi,
  output reg        o_spi_miso,
  output reg        o_spi_miso_oe,
  input  wire       i_set_sel,
  input  wire [1:0] i_sync_detect_mode,
  input  wire [4:0] i_gap_chips,
  input  wire       i_chip_valid,
  input  wire       i_chip,
  input  wire       i_sync_a_found,
  input  wire       i_bit_valid,
  input  wire       i_bit,
  input  wire       i_code_violation,
  input  wire       i_sync_lost,
  input  wire [7:0] i_fsk_noise,
  input  wire [5:0] i_ask_noise,
  input  wire [7:0] i_peak_level,
  output wire       o_bit_ready,
  output reg        o_sync_found,
  output reg        o_end_of_message,
  output reg        o_receiving,
  output wire       o_payload_valid,
  output wire       o_payload_bit,
  input  wire       i_payload_ready,
  output reg  [7:0] o_payload_peak_level
);
  // framer states
  localparam [1:0] ST_HUNT    = 2'h0;
  localparam [1:0] ST_GAP     = 2'h1;
  localparam [1:0] ST_MATCH_B = 2'h2;
  localparam [1:0] ST_PAYLOAD = 2'h3;

  // ---------------- serial port pin synchronisers ----------------
  wire [2:0] pin_raw;              // cs_n, clock, data in
  reg  [2:0] pin_s1;               // first stage, read only by second
  reg  [2:0] pin_s2;               // second stage
  reg  [2:0] pin_s3;               // third stage
  reg  [2:0] pin_clean;            // level accepted once stages two and three agree
  reg  [2:0] pin_prev;             // previous clean level for edge detection
  genvar     g;
  // reset to the resting levels, so no false clock edge follows reset
  localparam [2:0] PIN_IDLE = `EMD_PIN_IDLE;

  assign pin_raw = {i_spi_cs_n, i_spi_clk, i_spi_mosi};

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin_sync
      // three flops; a glitch seen by only one stage never counts
      always @(posedge i_clk) begin
        if (!i_reset_n) begin
          pin_s1[g]    <= PIN_IDLE[g];
          pin_s2[g]    <= PIN_IDLE[g];
          pin_s3[g]    <= PIN_IDLE[g];
          pin_clean[g] <= PIN_IDLE[g];
          pin_prev[g]  <= PIN_IDLE[g];
        end else begin
          pin_s1[g]   <= pin_raw[g];
          pin_s2[g]   <= pin_s1[g];
          pin_s3[g]   <= pin_s2[g];
          pin_prev[g] <= pin_clean[g];
          if (pin_s2[g] == pin_s3[g]) begin
            pin_clean[g] <= pin_s3[g];
          end
        end
      end
    end
  endgenerate

  wire cs_active = ~pin_clean[2];                      // frame open
  wire sck_rise  = pin_clean[1] & ~pin_prev[1];        // host samples-out edge
  wire sck_fall  = ~pin_clean[1] & pin_prev[1];        // device shifts out here
  wire mosi      = pin_clean[0];

  // ---------------- register storage ----------------
  reg  [7:0] cfg [0:7];        // index {set, field}; set a 0..3, set b 4..7
  reg  [7:0] fsk_noise;        // last measured frequency shift noise
  reg  [5:0] ask_noise;        // last measured amplitude shift noise

  // ---------------- serial port protocol ----------------
  reg  [7:0] spi_shift;        // incoming byte
  reg  [2:0] spi_bit_cnt;      // bits of current byte
  reg  [1:0] spi_byte_cnt;     // bytes of current frame, saturates at 3
  reg  [7:0] spi_cmd;          // first byte of frame
  reg  [7:0] spi_addr;         // second byte of frame
  reg  [7:0] miso_shift;       // outgoing read data
  reg        miso_load;        // load read data at next falling edge
  reg  [7:0] read_data;        // read mux result
  reg        cfg_hit;          // address lies in a configuration set
  reg  [2:0] cfg_index;        // storage index of that address
  wire [7:0] in_byte = {spi_shift[6:0], mosi};

  // address decode of the stored address byte into configuration index
  always @* begin
    cfg_hit   = 1'b1;
    cfg_index = 3'h0;
    if (spi_addr >= `EMD_ADDR_PAT_LO_A && spi_addr <= `EMD_ADDR_LEN_A) begin
      cfg_index = {1'b0, spi_addr[1:0]};
    end else if (spi_addr >= `EMD_ADDR_PAT_LO_B && spi_addr <= `EMD_ADDR_LEN_B) begin
      cfg_index = {1'b1, spi_addr[1:0]};
    end else begin
      cfg_hit = 1'b0;
    end
  end

  // read mux; write-only registers and holes read as zero
  always @* begin
    if (spi_addr == `EMD_ADDR_FSK_NOISE) begin
      read_data = fsk_noise;
    end else if (spi_addr == `EMD_ADDR_ASK_NOISE) begin
      read_data = {2'h0, ask_noise};
    end else if (spi_addr == `EMD_ADDR_PEAK) begin
      read_data = o_payload_peak_level;
    end else begin
      read_data = 8'h00;
    end
  end

  wire byte_done = sck_rise & (spi_bit_cnt == 3'h7);           // eighth bit sampled

  // serial frame handling: command, address, data
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      spi_shift     <= 8'h00;
      spi_bit_cnt   <= 3'h0;
      spi_byte_cnt  <= 2'h0;
      spi_cmd       <= 8'h00;
      spi_addr      <= 8'h00;
      miso_shift    <= 8'h00;
      miso_load     <= 1'b0;
      o_spi_miso    <= 1'b0;
      o_spi_miso_oe <= 1'b0;
    end else if (!cs_active) begin
      // frame closed: drop partial bytes, release the data line
      spi_bit_cnt   <= 3'h0;
      spi_byte_cnt  <= 2'h0;
      miso_load     <= 1'b0;
      o_spi_miso_oe <= 1'b0;
    end else begin
      o_spi_miso_oe <= (spi_cmd == `EMD_CMD_READ) && (spi_byte_cnt != 2'h0);
      if (sck_rise) begin
        spi_shift   <= in_byte;
        spi_bit_cnt <= spi_bit_cnt + 3'h1;
      end
      if (byte_done) begin
        if (spi_byte_cnt != 2'h3) begin
          spi_byte_cnt <= spi_byte_cnt + 2'h1;
        end
        if (spi_byte_cnt == 2'h0) begin
          spi_cmd <= in_byte;
        end else if (spi_byte_cnt == 2'h1) begin
          spi_addr  <= in_byte;
          miso_load <= (spi_cmd == `EMD_CMD_READ);
        end
      end
      // data goes out on falling edges so the host samples it on rising ones
      if (sck_fall) begin
        if (miso_load) begin
          o_spi_miso <= read_data[7];
          miso_shift <= {read_data[6:0], 1'b0};
          miso_load  <= 1'b0;
        end else begin
          o_spi_miso <= miso_shift[7];
          miso_shift <= {miso_shift[6:0], 1'b0};
        end
      end
    end
  end

  // configuration writes on third byte of a write frame
  integer k;
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      for (k = 0; k < 8; k = k + 1) begin
        cfg[k] <= `EMD_RESET_VAL;
      end
    end else if (cs_active && byte_done && spi_byte_cnt == 2'h2 &&
                 spi_cmd == `EMD_CMD_WRITE && cfg_hit) begin
      // unmapped and read-only addresses fall out of the decoder
      cfg[cfg_index] <= in_byte;
    end
  end

  // noise readouts follow the measurement, frozen while a read is pending
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      fsk_noise <= `EMD_RESET_VAL;
      ask_noise <= 6'h00;
    end else if (!miso_load) begin
      fsk_noise <= i_fsk_noise;
      ask_noise <= i_ask_noise;
    end
  end

  // ---------------- active set selection ----------------
  wire [15:0] pattern_b = {cfg[{i_set_sel, `EMD_IDX_PAT_HI}],
                           cfg[{i_set_sel, `EMD_IDX_PAT_LO}]};
  // unused control bits 3 to 7 are masked, so a host slip cannot enable anything
  wire [7:0]  end_ctrl  = cfg[{i_set_sel, `EMD_IDX_CTRL}] & `EMD_CTRL_USED_MASK;
  wire [7:0]  len_limit = cfg[{i_set_sel, `EMD_IDX_LEN}];

  // ---------------- framer ----------------
  reg  [1:0]  state;           // framer state
  reg  [15:0] chip_shift;      // last chips, newest in bit 0
  reg  [4:0]  chip_cnt;        // chips seen in current phase
  reg  [7:0]  bit_cnt;         // payload bits delivered
  wire [15:0] chips_now  = {chip_shift[14:0], i_chip};
  wire        parallel   = (i_sync_detect_mode == `EMD_MODE_PAR) ||
                           (i_sync_detect_mode == `EMD_MODE_EXT);
  wire        len_end    = end_ctrl[`EMD_CTRL_LEN_BIT] && i_bit_valid &&
                           (bit_cnt == len_limit);
  wire        cv_end     = end_ctrl[`EMD_CTRL_CV_BIT] && i_code_violation;
  wire        loss_end   = end_ctrl[`EMD_CTRL_LOSS_BIT] && i_sync_lost;
  wire        end_now    = (state == ST_PAYLOAD) &&
                           (len_end || cv_end || loss_end);
  wire        fifo_push  = (state == ST_PAYLOAD) && i_bit_valid && !end_now;

  // sync search, pattern b check and payload framing
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      state                <= ST_HUNT;
      chip_shift           <= 16'h0000;
      chip_cnt             <= 5'h00;
      bit_cnt              <= 8'h00;
      o_sync_found         <= 1'b0;
      o_end_of_message     <= 1'b0;
      o_receiving          <= 1'b0;
      o_payload_peak_level <= `EMD_RESET_VAL;
    end else begin
      o_sync_found     <= 1'b0;
      o_end_of_message <= 1'b0;
      if (i_chip_valid) begin
        chip_shift <= chips_now;
      end
      case (state)
        ST_HUNT: begin
          if (i_chip_valid && chip_cnt != `EMD_PATTERN_FULL) begin
            chip_cnt <= chip_cnt + 5'h01;
          end
          if (parallel) begin
            // either pattern alone opens the payload
            if (i_sync_a_found || (i_chip_valid && chip_cnt >= `EMD_PATTERN_LAST &&
                                   chips_now == pattern_b)) begin
              state        <= ST_PAYLOAD;
              o_sync_found <= 1'b1;
              o_receiving  <= 1'b1;
              bit_cnt      <= 8'h00;
            end
          end else if (i_sync_a_found) begin
            chip_cnt <= 5'h00;
            if (i_sync_detect_mode == `EMD_MODE_GAP && i_gap_chips != 5'h00) begin
              state <= ST_GAP;
            end else begin
              state <= ST_MATCH_B;
            end
          end
        end
        ST_GAP: begin
          // skip the programmed gap before pattern b starts
          if (i_chip_valid) begin
            if (chip_cnt + 5'h01 == i_gap_chips) begin
              chip_cnt <= 5'h00;
              state    <= ST_MATCH_B;
            end else begin
              chip_cnt <= chip_cnt + 5'h01;
            end
          end
        end
        ST_MATCH_B: begin
          if (i_chip_valid) begin
            chip_cnt <= chip_cnt + 5'h01;
            if (chip_cnt == `EMD_PATTERN_LAST) begin
              chip_cnt <= 5'h00;
              if (chips_now == pattern_b) begin
                state        <= ST_PAYLOAD;
                o_sync_found <= 1'b1;
                o_receiving  <= 1'b1;
                bit_cnt      <= 8'h00;
              end else begin
                state <= ST_HUNT;                              // mismatch, start over
              end
            end
          end
        end
        default: begin
          if (fifo_push && bit_cnt != 8'hff) begin
            bit_cnt <= bit_cnt + 8'h01;
          end
          if (end_now) begin
            o_end_of_message     <= 1'b1;
            o_payload_peak_level <= i_peak_level;
            o_receiving          <= 1'b0;
            chip_cnt             <= 5'h00;
            state                <= ST_HUNT;
          end
        end
      endcase
    end
  end

  // ---------------- payload buffer ----------------
  // a full buffer drops bits; o_bit_ready tells the bit source to hold off
  emd_fifo #(
    .WIDTH (`EMD_FIFO_WIDTH),
    .DEPTH (`EMD_FIFO_DEPTH),
    .AW    (`EMD_FIFO_AW)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (fifo_push),
    .i_in_data   (i_bit),
    .o_in_ready  (o_bit_ready),
    .o_out_valid (o_payload_valid),
    .o_out_data  (o_payload_bit),
    .i_out_ready (i_payload_ready)
  );
endmodule

// ==== rtl/emd_fifo.v ====
// payload fifo with registered output stage and registered input ready
`timescale 1ns/10ps
module emd_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_clk,
  input  wire             i_reset_n,
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output reg              o_in_ready,
  output reg              o_out_valid,
  output reg  [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready
);
  localparam [AW:0] DEPTH_W = DEPTH[AW:0];

  reg  [WIDTH-1:0] mem [0:DEPTH-1]; // storage entries
  reg  [AW-1:0]    wr_ptr;          // next entry to fill
  reg  [AW-1:0]    rd_ptr;          // next entry to drain
  reg  [AW:0]      count;           // entries held, output stage excluded
  wire             push;            // word accepted this cycle
  wire             pop;             // word moved to the output stage
  wire [AW:0]      next_count;      // count after this cycle

  assign push       = i_in_valid & o_in_ready;
  assign pop        = (count != {(AW+1){1'b0}}) & (~o_out_valid | i_out_ready);
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // storage has no reset, only pointers say what is valid
  always @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers, count, ready and output stage
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_ptr      <= {AW{1'b0}};
      rd_ptr      <= {AW{1'b0}};
      count       <= {(AW+1){1'b0}};
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
      o_out_data  <= {WIDTH{1'b0}};
    end else begin
      count      <= next_count;
      // ready is precomputed so the source sees full one cycle early enough
      o_in_ready <= (next_count < DEPTH_W);
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr      <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        o_out_data  <= mem[rd_ptr];
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
    end
  end
endmodule

// ==== rtl/emd_regs.vh ====
// register offsets, field positions, reset values and counts of the end-of-message block
`ifndef EMD_REGS_VH
`define EMD_REGS_VH

// register offsets, set a
`define EMD_ADDR_PAT_LO_A   8'h88
`define EMD_ADDR_PAT_HI_A   8'h89
`define EMD_ADDR_CTRL_A     8'h8a
`define EMD_ADDR_LEN_A      8'h8b
// register offsets, set b
`define EMD_ADDR_PAT_LO_B   8'ha8
`define EMD_ADDR_PAT_HI_B   8'ha9
`define EMD_ADDR_CTRL_B     8'haa
`define EMD_ADDR_LEN_B      8'hab
// read-only registers
`define EMD_ADDR_PEAK       8'hac
`define EMD_ADDR_FSK_NOISE  8'haf
`define EMD_ADDR_ASK_NOISE  8'hb0

// index of each register inside one configuration set
`define EMD_IDX_PAT_LO      2'h0
`define EMD_IDX_PAT_HI      2'h1
`define EMD_IDX_CTRL        2'h2
`define EMD_IDX_LEN         2'h3

// end-of-message control fields
`define EMD_CTRL_LEN_BIT    0
`define EMD_CTRL_CV_BIT     1
`define EMD_CTRL_LOSS_BIT   2
`define EMD_CTRL_USED_MASK  8'h07

// reset value of every register
`define EMD_RESET_VAL       8'h00
// idle levels of the serial pins {cs_n, clock, data in}
`define EMD_PIN_IDLE        3'h4

// serial port command bytes
`define EMD_CMD_WRITE       8'h02
`define EMD_CMD_READ        8'h03

// sync detection modes
`define EMD_MODE_SEQ        2'h0
`define EMD_MODE_PAR        2'h1
`define EMD_MODE_GAP        2'h2
`define EMD_MODE_EXT        2'h3

// pattern length in chips and payload buffer shape
`define EMD_PATTERN_LAST    5'h0f
`define EMD_PATTERN_FULL    5'h10
`define EMD_FIFO_WIDTH      1
`define EMD_FIFO_DEPTH      16
`define EMD_FIFO_AW         4

`endif

// ==== tb/emd_chk.sv ====
// assertion checker for the end-of-message block, bound to its top
`timescale 1ns/10ps
module emd_chk (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_spi_clk,
  input wire logic       i_spi_cs_n,
  input wire logic       i_bit_valid,
  input wire logic       i_code_violation,
  input wire logic       i_sync_lost,
  input wire logic       i_payload_ready,
  input wire logic       o_spi_miso,
  input wire logic       o_spi_miso_oe,
  input wire logic       o_sync_found,
  input wire logic       o_end_of_message,
  input wire logic       o_receiving,
  input wire logic       o_payload_valid,
  input wire logic       o_payload_bit,
  input wire logic [7:0] o_payload_peak_level
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // an end needs a payload bit, a violation or a loss one cycle before
  sequence s_cause;
    $past(i_bit_valid) || $past(i_code_violation) || $past(i_sync_lost);
  endsequence
  // the end pulse and the fall of the payload state go together
  sequence s_end;
    o_end_of_message && !o_receiving;
  endsequence
  property p_eom_cause;
    o_end_of_message |-> s_cause;
  endproperty
  property p_eom_pulse;
    o_end_of_message |=> !o_end_of_message;
  endproperty
  property p_eom_payload;
    o_end_of_message |-> $past(o_receiving);
  endproperty
  property p_recv_fall;
    $fell(o_receiving) |-> s_end;
  endproperty
  property p_sync_recv;
    o_sync_found |-> ##[0:1] o_receiving;
  endproperty
  property p_sync_pulse;
    o_sync_found |=> !o_sync_found;
  endproperty
  property p_peak;
    $changed(o_payload_peak_level) |-> o_end_of_message || $past(o_end_of_message);
  endproperty
  property p_hold;
    o_payload_valid && !i_payload_ready |=> o_payload_valid && $stable(o_payload_bit);
  endproperty
  property p_oe_rise;
    $rose(o_spi_miso_oe) |-> !i_spi_cs_n;
  endproperty
  property p_miso_move;
    $changed(o_spi_miso) |-> !i_spi_clk;
  endproperty
  a_eom_cause: assert property (p_eom_cause) else $error("end without cause");
  a_eom_pulse: assert property (p_eom_pulse) else $error("end pulse too long");
  a_eom_payload: assert property (p_eom_payload) else $error("end outside payload");
  a_recv_fall: assert property (p_recv_fall) else $error("payload left silently");
  a_sync_recv: assert property (p_sync_recv) else $error("no payload after sync");
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse too long");
  a_peak: assert property (p_peak) else $error("peak moved without end");
  a_hold: assert property (p_hold) else $error("payload output not held");
  a_oe_rise: assert property (p_oe_rise) else $error("drive outside frame");
  a_miso_move: assert property (p_miso_move) else $error("read data moved late");
endmodule
bind emd_end_of_message emd_chk u_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_spi_clk(i_spi_clk), .i_spi_cs_n(i_spi_cs_n),
  .i_bit_valid(i_bit_valid), .i_code_violation(i_code_violation),
  .i_sync_lost(i_sync_lost), .i_payload_ready(i_payload_ready), .o_spi_miso(o_spi_miso),
  .o_spi_miso_oe(o_spi_miso_oe), .o_sync_found(o_sync_found),
  .o_end_of_message(o_end_of_message), .o_receiving(o_receiving),
  .o_payload_valid(o_payload_valid), .o_payload_bit(o_payload_bit),
  .o_payload_peak_level(o_payload_peak_level));

// ==== tb/emd_host.sv ====
// host model driving the serial control port in mode 0
`timescale 1ns/10ps
module emd_host (
  input  wire logic i_clk,
  input  wire logic i_miso,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi
);
  int hp = 6; // half period in system clocks, raised to act as a slow host
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // one three-byte frame, msb first; the third byte read back lands in q
  task automatic xfer(input logic [23:0] f, output logic [7:0] q);
    o_cs_n = 1'b0;
    wait_clk(4);
    for (int i = 23; i >= 0; i--) begin
      o_mosi = f[i];
      wait_clk(hp);
      o_sclk = 1'b1;
      if (i < 8) q[i] = i_miso; // sampled on the rising edge
      wait_clk(hp);
      o_sclk = 1'b0;
    end
    wait_clk(hp);
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // released line never keeps showing the last bit
    wait_clk(6);
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the end-of-message block
`timescale 1ns/10ps
`include "emd_regs.vh"
module testbench;
  logic       i_clk, i_reset_n, i_set_sel, i_chip_valid, i_chip, i_sync_a_found;
  logic       i_bit_valid, i_bit, i_code_violation, i_sync_lost, i_payload_ready;
  logic [1:0] i_sync_detect_mode;
  logic [4:0] i_gap_chips;
  logic [7:0] i_fsk_noise, i_peak_level;
  logic [5:0] i_ask_noise;
  wire        sclk, cs_n, mosi, miso, oe, bit_ready, sync_found, end_of_message, recv, pv, pb;
  wire  [7:0] peak;
  int         error_cnt, checks, n_sync, n_eom, cyc;
  logic       rx[$]; // payload bits taken from the buffer
  emd_end_of_message uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_spi_clk(sclk),
    .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe),
    .i_set_sel(i_set_sel), .i_sync_detect_mode(i_sync_detect_mode),
    .i_gap_chips(i_gap_chips), .i_chip_valid(i_chip_valid), .i_chip(i_chip),
    .i_sync_a_found(i_sync_a_found), .i_bit_valid(i_bit_valid), .i_bit(i_bit),
    .i_code_violation(i_code_violation), .i_sync_lost(i_sync_lost),
    .i_fsk_noise(i_fsk_noise), .i_ask_noise(i_ask_noise), .i_peak_level(i_peak_level),
    .o_bit_ready(bit_ready), .o_sync_found(sync_found), .o_end_of_message(end_of_message),
    .o_receiving(recv), .o_payload_valid(pv), .o_payload_bit(pb),
    .i_payload_ready(i_payload_ready), .o_payload_peak_level(peak));
  // a released data line rests at its pull-up level
  emd_host host (.i_clk(i_clk), .i_miso(oe ? miso : 1'b1), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_mosi(mosi));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // event counters, buffer sink and hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (sync_found === 1'b1) n_sync++;
    if (end_of_message === 1'b1) n_eom++;
    if (pv === 1'b1 && i_payload_ready === 1'b1) rx.push_back(pb);
    if (cyc == 60000) begin
      error_cnt++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer({`EMD_CMD_WRITE, a, d}, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.xfer({`EMD_CMD_READ, a, 8'h00}, q);
    chk(q, exp);
  endtask
  // one set: pattern b, end control with bit three kept clear, limit
  task automatic cfg(input logic [7:0] b, input logic [15:0] p, input logic [7:0] c,
                     input logic [7:0] len);
    wr(b, p[7:0]);
    wr(b + 8'h01, p[15:8]);
    wr(b + 8'h02, c & 8'hf7);
    wr(b + 8'h03, len);
  endtask
  task automatic chip(input logic c);
    i_chip_valid = 1'b1;
    i_chip = c;
    step(1);
    i_chip_valid = 1'b0;
    step(1);
  endtask
  // optional sync a pulse, skipped chips, then pattern chips oldest first
  task automatic hunt(input logic a, input logic [15:0] p, input int skip);
    i_sync_a_found = a;
    step(1);
    i_sync_a_found = 1'b0;
    repeat (skip) chip(1'b1);
    for (int i = 15; i >= 0; i--) chip(p[i]);
    step(3);
  endtask
  task automatic bit1(input logic b);
    i_bit_valid = 1'b1;
    i_bit = b;
    step(1);
    i_bit_valid = 1'b0;
    step(3);
  endtask
  // one-cycle violation (cv high) or sync loss (cv low)
  task automatic cause(input logic cv);
    i_code_violation = cv;
    i_sync_lost = !cv;
    step(1);
    i_code_violation = 1'b0;
    i_sync_lost = 1'b0;
    step(3);
  endtask
  task automatic t_regs;
    i_fsk_noise = 8'hc5;
    i_ask_noise = 6'h2a;
    rd(`EMD_ADDR_FSK_NOISE, 8'hc5);
    host.hp = 11; // slow host
    rd(`EMD_ADDR_ASK_NOISE, 8'h2a);
    host.hp = 6;
    rd(`EMD_ADDR_PEAK, 8'h00);
    rd(`EMD_ADDR_CTRL_A, 8'h00);
    rd(8'h00, 8'h00);
    chk(oe, 1'b0);
  endtask
  // reset config: pattern zero matches, no criterion ends the message
  task automatic t_reset_cfg;
    int e;
    e = n_eom;
    hunt(1'b1, 16'h0000, 0);
    chk(n_sync, 1);
    cause(1'b1);
    cause(1'b0);
    chk(n_eom, e);
    i_reset_n = 1'b0;
    step(2);
    i_reset_n = 1'b1;
    step(8);
    chk(recv, 1'b0);
  endtask
  task automatic t_len;
    int s;
    cfg(`EMD_ADDR_PAT_LO_A, 16'ha5c3, 8'h01, 8'h03);
    s = n_sync;
    hunt(1'b1, 16'ha5c1, 0);
    hunt(1'b0, 16'ha5c3, 0);
    chk(n_sync, s);
    hunt(1'b1, 16'ha5c3, 0);
    chk(n_sync, s + 1);
    rx.delete();
    s = n_eom;
    i_peak_level = 8'h5a;
    bit1(1'b1);
    bit1(1'b0);
    bit1(1'b1);
    chk(n_eom, s);
    bit1(1'b0);
    chk(n_eom, s + 1);
    chk(recv, 1'b0);
    bit1(1'b1);
    chk(rx.size(), 3);
    chk({rx[0], rx[1], rx[2]}, 3'h5);
    chk(peak, 8'h5a);
    rd(`EMD_ADDR_PEAK, 8'h5a);
  endtask
  // parallel modes: pattern b alone, or a sync a pulse alone, opens the payload
  task automatic t_par_b(input logic [1:0] m, input logic a);
    int e;
    i_set_sel = 1'b1;
    i_sync_detect_mode = m;
    cfg(`EMD_ADDR_PAT_LO_B, 16'h3c96, 8'h01, 8'h00);
    e = n_sync;
    hunt(a, 16'h3c96, 0);
    chk(n_sync, e + 1);
    rx.delete();
    e = n_eom;
    bit1(1'b1);
    chk(n_eom, e + 1);
    chk(rx.size(), 0);
    i_set_sel = 1'b0;
  endtask
  task automatic t_mix(input logic [1:0] m, input int gap);
    int e;
    i_sync_detect_mode = m;
    i_gap_chips = gap;
    cfg(`EMD_ADDR_PAT_LO_A, 16'h0ff0, 8'h04, 8'h00);
    hunt(1'b1, 16'h0ff0, gap);
    e = n_eom;
    cause(1'b1);
    chk(n_eom, e);
    cause(1'b0);
    chk(n_eom, e + 1);
    wr(`EMD_ADDR_CTRL_A, 8'h06);
    hunt(1'b1, 16'h0ff0, gap);
    cause(1'b1);
    chk(n_eom, e + 2);
  endtask
  // buffer fills while the sink stalls, then drains whole
  task automatic t_fifo;
    int acc;
    i_sync_detect_mode = `EMD_MODE_SEQ;
    cfg(`EMD_ADDR_PAT_LO_A, 16'h0ff0, 8'h05, 8'hff);
    hunt(1'b1, 16'h0ff0, 0);
    rx.delete();
    i_payload_ready = 1'b0;
    acc = 0;
    for (int i = 0; i < 20; i++) begin
      if (bit_ready === 1'b1) acc++;
      bit1(i[0]);
    end
    chk(bit_ready, 1'b0);
    chk(acc, `EMD_FIFO_DEPTH + 1);
    chk(recv, 1'b1);
    i_payload_ready = 1'b1;
    step(40);
    chk(rx.size(), acc);
    chk({rx[0], rx[1], rx[16]}, 3'h2);
    cause(1'b0);
    chk(recv, 1'b0);
  endtask
  initial begin
    {i_set_sel, i_chip_valid, i_chip, i_sync_a_found, i_bit_valid, i_bit} = 6'h00;
    {i_code_violation, i_sync_lost, i_sync_detect_mode, i_gap_chips} = 9'h000;
    {i_fsk_noise, i_ask_noise, i_peak_level} = 22'h000000;
    i_payload_ready = 1'b1;
    i_reset_n = 1'b0;
    step(2);
    i_reset_n = 1'b1;
    step(8);
    t_regs;
    t_reset_cfg;
    t_len;
    t_par_b(`EMD_MODE_PAR, 1'b0);
    t_par_b(`EMD_MODE_EXT, 1'b1);
    t_mix(`EMD_MODE_SEQ, 0);
    t_mix(`EMD_MODE_GAP, 5);
    t_fifo;
    complete_run;
  end
endmodule
